// ---- design/fault_limit_monitor_params.svh ----
// constants of the fault and warning limit monitor
`ifndef FLM_FAULT_LIMIT_MONITOR_PARAMS_SVH
`define FLM_FAULT_LIMIT_MONITOR_PARAMS_SVH

// register byte addresses
`define FLM_ADDR_CTRL        8'h00
`define FLM_ADDR_CLEAR       8'h04
`define FLM_ADDR_VOUT_TARGET 8'h08
`define FLM_ADDR_OV_WARN     8'h0C
`define FLM_ADDR_UV_WARN     8'h10
`define FLM_ADDR_UV_FAULT    8'h14
`define FLM_ADDR_OC_FAULT    8'h18
`define FLM_ADDR_OC_LV       8'h1C
`define FLM_ADDR_OC_WARN     8'h20
`define FLM_ADDR_UC_FAULT    8'h24
`define FLM_ADDR_OT_FAULT    8'h28
`define FLM_ADDR_OT_WARN     8'h2C
`define FLM_ADDR_UV_RESP     8'h30
`define FLM_ADDR_OC_RESP     8'h34
`define FLM_ADDR_OC_LV_RESP  8'h38
`define FLM_ADDR_UC_RESP     8'h3C
`define FLM_ADDR_OT_RESP     8'h40
`define FLM_ADDR_STAT_BYTE   8'h44
`define FLM_ADDR_STAT_WORD   8'h48
`define FLM_ADDR_STAT_VOUT   8'h4C
`define FLM_ADDR_STAT_IOUT   8'h50
`define FLM_ADDR_STAT_TEMP   8'h54

// reset values
`define FLM_RST_ZERO16       16'h0000
`define FLM_RST_MAX16        16'hFFFF
`define FLM_RST_SMAX16       16'h7FFF
`define FLM_RST_RESP         2'h0

// response actions
`define FLM_RESP_IGNORE      2'h0
`define FLM_RESP_LIMIT       2'h1
`define FLM_RESP_INHIBIT     2'h2

// control register bits
`define FLM_CTRL_ENABLE      0

// summary status byte bits
`define FLM_SB_OTHER         0
`define FLM_SB_TEMP          2
`define FLM_SB_IOUT_OC       4
// status word upper byte bits
`define FLM_SW_IOUT          14
`define FLM_SW_VOUT          15
// output-voltage status bits
`define FLM_SV_UV_FAULT      4
`define FLM_SV_UV_WARN       5
`define FLM_SV_OV_WARN       6
// output-current status bits
`define FLM_SI_UC_FAULT      4
`define FLM_SI_OC_WARN       5
`define FLM_SI_OC_LV_FAULT   6
`define FLM_SI_OC_FAULT      7
// temperature status bits
`define FLM_ST_OT_WARN       6
`define FLM_ST_OT_FAULT      7

`endif

// ---- design/flm_pkg.sv ----
// types shared by the fault and warning limit monitor
package flm_pkg;
    typedef logic [15:0] flm_word_t;
    typedef logic [7:0]  flm_byte_t;
    typedef logic [7:0]  flm_addr_t;
    typedef logic [1:0]  flm_resp_t;
endpackage : flm_pkg

// ---- design/flm_fault_limit_monitor.sv ----
// fault and warning limit monitor with status registers and responses
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "fault_limit_monitor_params.svh"

module flm_fault_limit_monitor
    import flm_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // register port
    input  wire flm_addr_t   reg_addr,
    input  wire flm_word_t   reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output flm_word_t        reg_rdata,
    // measurements
    input  wire flm_word_t   meas_vout,
    input  wire flm_word_t   meas_iout,
    input  wire flm_word_t   meas_temp,
    input  wire logic        meas_valid,
    // notification and responses
    output logic             alert_n,
    output logic             warn_notify,
    output logic             fault_notify,
    output logic             output_inhibit,
    output logic             sync_rect_off,
    output logic             cc_limit
);

    function automatic logic is_inhibit(input flm_resp_t r);
        is_inhibit = (r == `FLM_RESP_INHIBIT);
    endfunction : is_inhibit

    function automatic logic sgt(input flm_word_t a, input flm_word_t b);
        sgt = ($signed(a) > $signed(b));
    endfunction : sgt

    // reset release
    logic        rst_s1_reg;
    logic        rst_s2_reg;
    logic        rst_n;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    // configuration registers
    logic        enable_reg;
    flm_word_t   vout_target_reg;
    flm_word_t   ov_warn_reg;
    flm_word_t   uv_warn_reg;
    flm_word_t   uv_fault_reg;
    flm_word_t   oc_fault_reg;
    flm_word_t   oc_lv_reg;
    flm_word_t   oc_warn_reg;
    flm_word_t   uc_fault_reg;
    flm_word_t   ot_fault_reg;
    flm_word_t   ot_warn_reg;
    flm_resp_t   uv_resp_reg;
    flm_resp_t   oc_resp_reg;
    flm_resp_t   oc_lv_resp_reg;
    flm_resp_t   uc_resp_reg;
    flm_resp_t   ot_resp_reg;
    logic        clear_cmd;

    assign clear_cmd = reg_wr && (reg_addr == `FLM_ADDR_CLEAR);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_reg      <= 1'b0;
            vout_target_reg <= `FLM_RST_ZERO16;
            ov_warn_reg     <= `FLM_RST_MAX16;
            uv_warn_reg     <= `FLM_RST_ZERO16;
            uv_fault_reg    <= `FLM_RST_ZERO16;
            oc_fault_reg    <= `FLM_RST_SMAX16;
            oc_lv_reg       <= `FLM_RST_ZERO16;
            oc_warn_reg     <= `FLM_RST_SMAX16;
            uc_fault_reg    <= `FLM_RST_ZERO16;
            ot_fault_reg    <= `FLM_RST_SMAX16;
            ot_warn_reg     <= `FLM_RST_SMAX16;
            uv_resp_reg     <= `FLM_RST_RESP;
            oc_resp_reg     <= `FLM_RST_RESP;
            oc_lv_resp_reg  <= `FLM_RST_RESP;
            uc_resp_reg     <= `FLM_RST_RESP;
            ot_resp_reg     <= `FLM_RST_RESP;
        end
        else if (reg_wr)
        begin
            // limits are stored as raw two-byte words
            case (reg_addr)
                `FLM_ADDR_CTRL:        enable_reg      <= reg_wdata[`FLM_CTRL_ENABLE];
                `FLM_ADDR_VOUT_TARGET: vout_target_reg <= reg_wdata;
                `FLM_ADDR_OV_WARN:     ov_warn_reg     <= reg_wdata;
                `FLM_ADDR_UV_WARN:     uv_warn_reg     <= reg_wdata;
                `FLM_ADDR_UV_FAULT:    uv_fault_reg    <= reg_wdata;
                `FLM_ADDR_OC_FAULT:    oc_fault_reg    <= reg_wdata;
                `FLM_ADDR_OC_LV:       oc_lv_reg       <= reg_wdata;
                `FLM_ADDR_OC_WARN:     oc_warn_reg     <= reg_wdata;
                `FLM_ADDR_UC_FAULT:    uc_fault_reg    <= reg_wdata;
                `FLM_ADDR_OT_FAULT:    ot_fault_reg    <= reg_wdata;
                `FLM_ADDR_OT_WARN:     ot_warn_reg     <= reg_wdata;
                `FLM_ADDR_UV_RESP:     uv_resp_reg     <= reg_wdata[1:0];
                `FLM_ADDR_OC_RESP:     oc_resp_reg     <= reg_wdata[1:0];
                `FLM_ADDR_OC_LV_RESP:  oc_lv_resp_reg  <= reg_wdata[1:0];
                `FLM_ADDR_UC_RESP:     uc_resp_reg     <= reg_wdata[1:0];
                `FLM_ADDR_OT_RESP:     ot_resp_reg     <= reg_wdata[1:0];
                default:               enable_reg      <= enable_reg;
            endcase
        end
    end

    // comparisons, refreshed on every measurement
    logic        c_ov_warn_reg;
    logic        c_uv_warn_reg;
    logic        c_uv_fault_reg;
    logic        c_oc_fault_reg;
    logic        c_oc_lv_reg;
    logic        c_oc_warn_reg;
    logic        c_uc_fault_reg;
    logic        c_ot_fault_reg;
    logic        c_ot_warn_reg;
    logic        reached_reg;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            c_ov_warn_reg  <= 1'b0;
            c_uv_warn_reg  <= 1'b0;
            c_uv_fault_reg <= 1'b0;
            c_oc_fault_reg <= 1'b0;
            c_oc_lv_reg    <= 1'b0;
            c_oc_warn_reg  <= 1'b0;
            c_uc_fault_reg <= 1'b0;
            c_ot_fault_reg <= 1'b0;
            c_ot_warn_reg  <= 1'b0;
        end
        else if (meas_valid)
        begin
            c_ov_warn_reg  <= meas_vout > ov_warn_reg;
            c_uv_warn_reg  <= meas_vout < uv_warn_reg;
            c_uv_fault_reg <= meas_vout < uv_fault_reg;
            c_oc_fault_reg <= sgt(meas_iout, oc_fault_reg);
            c_oc_lv_reg    <= meas_vout < oc_lv_reg;
            c_oc_warn_reg  <= sgt(meas_iout, oc_warn_reg);
            c_uc_fault_reg <= sgt(uc_fault_reg, meas_iout);
            c_ot_fault_reg <= sgt(meas_temp, ot_fault_reg);
            c_ot_warn_reg  <= sgt(meas_temp, ot_warn_reg);
        end
    end

    // output has reached its programmed voltage since enable
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reached_reg <= 1'b0;
        else if (!enable_reg)
            reached_reg <= 1'b0;
        else if (meas_valid && (meas_vout >= vout_target_reg))
            reached_reg <= 1'b1;
    end

    // live events after masking
    logic        uv_mask_open;
    logic        ev_uv_warn;
    logic        ev_uv_fault;
    logic        ev_oc_fault;
    logic        ev_oc_lv;

    assign uv_mask_open = enable_reg && reached_reg;
    assign ev_uv_warn   = c_uv_warn_reg && uv_mask_open;
    assign ev_uv_fault  = c_uv_fault_reg && uv_mask_open;
    assign ev_oc_fault  = c_oc_fault_reg;
    assign ev_oc_lv     = c_oc_fault_reg && c_oc_lv_reg;

    // detailed and summary status
    flm_byte_t   stat_vout_reg;
    flm_byte_t   stat_iout_reg;
    flm_byte_t   stat_temp_reg;
    flm_byte_t   stat_byte_reg;
    logic [1:0]  stat_word_hi_reg;
    flm_byte_t   sv_set;
    flm_byte_t   si_set;
    flm_byte_t   st_set;
    flm_byte_t   sb_set;
    logic [1:0]  sw_set;
    flm_byte_t   sv_next;
    flm_byte_t   si_next;
    flm_byte_t   st_next;
    flm_byte_t   sb_next;
    logic [1:0]  sw_next;
    logic        warn_new;
    logic        fault_new;

    always_comb
    begin
        sv_set = '0;
        si_set = '0;
        st_set = '0;
        sb_set = '0;
        sw_set = '0;
        sv_set[`FLM_SV_OV_WARN]     = c_ov_warn_reg;
        sv_set[`FLM_SV_UV_WARN]     = ev_uv_warn;
        sv_set[`FLM_SV_UV_FAULT]    = ev_uv_fault;
        si_set[`FLM_SI_OC_FAULT]    = ev_oc_fault;
        si_set[`FLM_SI_OC_LV_FAULT] = ev_oc_lv;
        si_set[`FLM_SI_OC_WARN]     = c_oc_warn_reg;
        si_set[`FLM_SI_UC_FAULT]    = c_uc_fault_reg;
        st_set[`FLM_ST_OT_FAULT]    = c_ot_fault_reg;
        st_set[`FLM_ST_OT_WARN]     = c_ot_warn_reg;
        sb_set[`FLM_SB_OTHER]       = |sv_set || c_oc_warn_reg || c_uc_fault_reg;
        sb_set[`FLM_SB_IOUT_OC]     = ev_oc_fault;
        sb_set[`FLM_SB_TEMP]        = |st_set;
        sw_set[`FLM_SW_VOUT - `FLM_SW_IOUT] = |sv_set;
        sw_set[0]                   = |si_set;
        // a set in the clearing cycle wins, so a live condition stays flagged
        sv_next = (clear_cmd ? '0 : stat_vout_reg) | sv_set;
        si_next = (clear_cmd ? '0 : stat_iout_reg) | si_set;
        st_next = (clear_cmd ? '0 : stat_temp_reg) | st_set;
        sb_next = (clear_cmd ? '0 : stat_byte_reg) | sb_set;
        sw_next = (clear_cmd ? '0 : stat_word_hi_reg) | sw_set;
        // newly set bits, counted against the cleared value
        warn_new  = |(sv_next & ~(clear_cmd ? '0 : stat_vout_reg)
                      & ((8'h01 << `FLM_SV_OV_WARN) | (8'h01 << `FLM_SV_UV_WARN)))
                  || |(si_next & ~(clear_cmd ? '0 : stat_iout_reg) & (8'h01 << `FLM_SI_OC_WARN))
                  || |(st_next & ~(clear_cmd ? '0 : stat_temp_reg) & (8'h01 << `FLM_ST_OT_WARN));
        fault_new = |(sv_next & ~(clear_cmd ? '0 : stat_vout_reg) & (8'h01 << `FLM_SV_UV_FAULT))
                  || |(si_next & ~(clear_cmd ? '0 : stat_iout_reg) & ~(8'h01 << `FLM_SI_OC_WARN))
                  || |(st_next & ~(clear_cmd ? '0 : stat_temp_reg) & (8'h01 << `FLM_ST_OT_FAULT));
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat_vout_reg    <= '0;
            stat_iout_reg    <= '0;
            stat_temp_reg    <= '0;
            stat_byte_reg    <= '0;
            stat_word_hi_reg <= '0;
        end
        else
        begin
            stat_vout_reg    <= sv_next;
            stat_iout_reg    <= si_next;
            stat_temp_reg    <= st_next;
            stat_byte_reg    <= sb_next;
            stat_word_hi_reg <= sw_next;
        end
    end

    // host notification
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            warn_notify  <= 1'b0;
            fault_notify <= 1'b0;
            alert_n      <= 1'b1;
        end
        else
        begin
            warn_notify  <= warn_new;
            fault_notify <= fault_new;
            alert_n      <= !(|sv_next || |si_next || |st_next);
        end
    end

    // fault responses; a latched shutdown ends only when the unit is disabled
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            output_inhibit <= 1'b0;
            sync_rect_off  <= 1'b0;
            cc_limit       <= 1'b0;
        end
        else
        begin
            if (!enable_reg)
                output_inhibit <= 1'b0;
            else if ((ev_uv_fault && is_inhibit(uv_resp_reg))
                  || (ev_oc_fault && !c_oc_lv_reg && is_inhibit(oc_resp_reg))
                  || (ev_oc_lv && is_inhibit(oc_lv_resp_reg))
                  || (c_ot_fault_reg && is_inhibit(ot_resp_reg)))
                output_inhibit <= 1'b1;
            if (!enable_reg)
                sync_rect_off <= 1'b0;
            else if (c_uc_fault_reg && is_inhibit(uc_resp_reg))
                sync_rect_off <= 1'b1;
            cc_limit <= ev_oc_fault && !c_oc_lv_reg && (oc_resp_reg == `FLM_RESP_LIMIT);
        end
    end

    // register read, data one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                `FLM_ADDR_CTRL:        reg_rdata <= {15'h0000, enable_reg};
                `FLM_ADDR_VOUT_TARGET: reg_rdata <= vout_target_reg;
                `FLM_ADDR_OV_WARN:     reg_rdata <= ov_warn_reg;
                `FLM_ADDR_UV_WARN:     reg_rdata <= uv_warn_reg;
                `FLM_ADDR_UV_FAULT:    reg_rdata <= uv_fault_reg;
                `FLM_ADDR_OC_FAULT:    reg_rdata <= oc_fault_reg;
                `FLM_ADDR_OC_LV:       reg_rdata <= oc_lv_reg;
                `FLM_ADDR_OC_WARN:     reg_rdata <= oc_warn_reg;
                `FLM_ADDR_UC_FAULT:    reg_rdata <= uc_fault_reg;
                `FLM_ADDR_OT_FAULT:    reg_rdata <= ot_fault_reg;
                `FLM_ADDR_OT_WARN:     reg_rdata <= ot_warn_reg;
                `FLM_ADDR_UV_RESP:     reg_rdata <= {14'h0000, uv_resp_reg};
                `FLM_ADDR_OC_RESP:     reg_rdata <= {14'h0000, oc_resp_reg};
                `FLM_ADDR_OC_LV_RESP:  reg_rdata <= {14'h0000, oc_lv_resp_reg};
                `FLM_ADDR_UC_RESP:     reg_rdata <= {14'h0000, uc_resp_reg};
                `FLM_ADDR_OT_RESP:     reg_rdata <= {14'h0000, ot_resp_reg};
                `FLM_ADDR_STAT_BYTE:   reg_rdata <= {8'h00, stat_byte_reg};
                `FLM_ADDR_STAT_WORD:   reg_rdata <= {stat_word_hi_reg, 6'h00, stat_byte_reg};
                `FLM_ADDR_STAT_VOUT:   reg_rdata <= {8'h00, stat_vout_reg};
                `FLM_ADDR_STAT_IOUT:   reg_rdata <= {8'h00, stat_iout_reg};
                `FLM_ADDR_STAT_TEMP:   reg_rdata <= {8'h00, stat_temp_reg};
                default:               reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end

endmodule : flm_fault_limit_monitor

// ---- bench/flm_checker_monitor.sv ----
// port checker of the fault limit monitor
`timescale 1ns/1ps
`include "fault_limit_monitor_params.svh"

module flm_checker_monitor
    import flm_pkg::*;
(
    // clock and reset
    input wire logic      ref_clk,
    input wire logic      reset_n,
    // register port
    input wire flm_addr_t reg_addr,
    input wire flm_word_t reg_wdata,
    input wire logic      reg_wr,
    input wire logic      reg_rd,
    input wire flm_word_t reg_rdata,
    // measurement, notification and responses
    input wire logic      meas_valid,
    input wire logic      alert_n,
    input wire logic      warn_notify,
    input wire logic      fault_notify,
    input wire logic      output_inhibit,
    input wire logic      sync_rect_off
);
    logic en_reg;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // shadow of the enable bit, inhibits may only drop once it is off
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            en_reg <= 1'b0;
        else if (reg_wr && reg_addr == `FLM_ADDR_CTRL)
            en_reg <= reg_wdata[`FLM_CTRL_ENABLE];
    end

    rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    rd_refused_a: assert property ($past(reg_rd) && ($past(reg_addr) == `FLM_ADDR_CLEAR
        || $past(reg_addr) > `FLM_ADDR_STAT_TEMP) |-> reg_rdata == 16'h0000)
        else $error("refused read returned data");
    stat_upper_a: assert property ($past(reg_rd) && $past(reg_addr) inside {`FLM_ADDR_STAT_BYTE,
        `FLM_ADDR_STAT_VOUT, `FLM_ADDR_STAT_IOUT, `FLM_ADDR_STAT_TEMP} |-> reg_rdata[15:8] == 8'h00)
        else $error("status byte read with upper bits set");
    warn_alert_a: assert property (warn_notify |-> !alert_n)
        else $error("warning notified without alert");
    fault_alert_a: assert property (fault_notify |-> !alert_n)
        else $error("fault notified without alert");
    alert_sticky_a: assert property (!alert_n && !(reg_wr && reg_addr == `FLM_ADDR_CLEAR) |=> !alert_n)
        else $error("alert released without clear");
    inhibit_hold_a: assert property (output_inhibit && en_reg
        && !(reg_wr && reg_addr == `FLM_ADDR_CTRL) |=> output_inhibit)
        else $error("output inhibit dropped while enabled");
    rect_hold_a: assert property (sync_rect_off && en_reg
        && !(reg_wr && reg_addr == `FLM_ADDR_CTRL) |=> sync_rect_off)
        else $error("rectifier stop dropped while enabled");
    notify_cause_a: assert property (warn_notify || fault_notify
        |-> $past(meas_valid, 2) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("notify without measurement or clear");
endmodule : flm_checker_monitor

bind flm_fault_limit_monitor flm_checker_monitor u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .meas_valid(meas_valid), .alert_n(alert_n), .warn_notify(warn_notify),
    .fault_notify(fault_notify), .output_inhibit(output_inhibit), .sync_rect_off(sync_rect_off));

// ---- bench/flm_meas_source.sv ----
// measurement source standing in for the power stage sensors
`timescale 1ns/1ps

module flm_meas_source
    import flm_pkg::*;
(
    // clock and reset
    input  wire logic      ref_clk,
    input  wire logic      reset_n,
    // request from the bench
    input  wire logic      src_go,
    input  wire flm_word_t src_vout,
    input  wire flm_word_t src_iout,
    input  wire flm_word_t src_temp,
    // measurement bus
    output flm_word_t      meas_vout,
    output flm_word_t      meas_iout,
    output flm_word_t      meas_temp,
    output logic           meas_valid
);
    // outside the valid pulse the buses toggle so stale data never looks good
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meas_valid <= 1'b0;
            meas_vout  <= 16'h0000;
            meas_iout  <= 16'h0000;
            meas_temp  <= 16'h0000;
        end
        else
        begin
            meas_valid <= src_go;
            meas_vout  <= src_go ? src_vout : ~meas_vout;
            meas_iout  <= src_go ? src_iout : ~meas_iout;
            meas_temp  <= src_go ? src_temp : ~meas_temp;
        end
    end
endmodule : flm_meas_source

// ---- bench/flm_fault_limit_monitor_test.sv ----
// self-checking testbench of the fault limit monitor
`timescale 1ns/1ps
`include "fault_limit_monitor_params.svh"

module flm_fault_limit_monitor_test
    import flm_pkg::*;
    ;
    logic      ref_clk, reset_n, reg_wr, reg_rd, meas_valid, src_go;
    logic      alert_n, warn_notify, fault_notify, output_inhibit, sync_rect_off, cc_limit;
    flm_addr_t reg_addr;
    flm_word_t reg_wdata, reg_rdata, meas_vout, meas_iout, meas_temp, src_vout, src_iout, src_temp;
    int        bad_count, checked, n_warn, n_fault;
    localparam flm_word_t INH = {14'h0000, `FLM_RESP_INHIBIT};

    flm_fault_limit_monitor dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .meas_vout(meas_vout), .meas_iout(meas_iout), .meas_temp(meas_temp), .meas_valid(meas_valid),
        .alert_n(alert_n), .warn_notify(warn_notify), .fault_notify(fault_notify),
        .output_inhibit(output_inhibit), .sync_rect_off(sync_rect_off), .cc_limit(cc_limit));
    flm_meas_source u_src (.ref_clk(ref_clk), .reset_n(reset_n), .src_go(src_go), .src_vout(src_vout),
        .src_iout(src_iout), .src_temp(src_temp), .meas_vout(meas_vout), .meas_iout(meas_iout),
        .meas_temp(meas_temp), .meas_valid(meas_valid));

    always #5 ref_clk = ~ref_clk;

    // pulse counters
    always @(posedge ref_clk)
    begin
        if (warn_notify === 1'b1) n_warn++;
        if (fault_notify === 1'b1) n_fault++;
    end

    function automatic flm_word_t flags();
        return {12'h000, alert_n, output_inhibit, sync_rect_off, cc_limit};
    endfunction : flags

    task automatic check(input flm_word_t seen, input flm_word_t exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input flm_addr_t a, input flm_word_t d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input flm_addr_t a, input flm_word_t exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        check(reg_rdata, exp);
    endtask : rd

    // one sample, returns once status has settled
    task automatic measure(input flm_word_t v, input flm_word_t i, input flm_word_t t);
        @(posedge ref_clk);
        src_vout <= v;
        src_iout <= i;
        src_temp <= t;
        src_go   <= 1'b1;
        @(posedge ref_clk);
        src_go   <= 1'b0;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : measure

    task automatic stat(input flm_byte_t b, input flm_byte_t w, input flm_byte_t v, input flm_byte_t i,
                        input flm_byte_t t);
        rd(`FLM_ADDR_STAT_BYTE, {8'h00, b});
        rd(`FLM_ADDR_STAT_WORD, {w, b});
        rd(`FLM_ADDR_STAT_VOUT, {8'h00, v});
        rd(`FLM_ADDR_STAT_IOUT, {8'h00, i});
        rd(`FLM_ADDR_STAT_TEMP, {8'h00, t});
    endtask : stat

    task automatic do_reset();
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        n_warn = 0;
        n_fault = 0;
    endtask : do_reset

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    initial
    begin
        #200_000;
        bad_count++;
        end_of_test();
    end

    initial
    begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        {reg_wr, reg_rd, src_go} = 3'h0;
        reg_addr = 8'h00;
        {reg_wdata, src_vout, src_iout, src_temp} = 64'h0000_0000_0000_0000;
        do_reset();
        rd(`FLM_ADDR_UV_FAULT, 16'h0000);
        rd(`FLM_ADDR_OC_LV, 16'h0000);
        rd(`FLM_ADDR_UC_FAULT, 16'h0000);
        rd(`FLM_ADDR_OV_WARN, 16'hffff);
        rd(`FLM_ADDR_OC_FAULT, 16'h7fff);
        wr(8'h58, 16'h1234);
        rd(8'h58, 16'h0000);
        rd(`FLM_ADDR_CLEAR, 16'h0000);
        $display("test reset values done");
        wr(`FLM_ADDR_OV_WARN, 16'h03e8);
        measure(16'h03e8, 16'h0000, 16'h0000);
        stat(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        measure(16'h03e9, 16'h0000, 16'h0000);
        stat(8'h01, 8'h80, 8'h40, 8'h00, 8'h00);
        check(flags(), 16'h0000);
        measure(16'h01f4, 16'h0000, 16'h0000);
        stat(8'h01, 8'h80, 8'h40, 8'h00, 8'h00);
        wr(`FLM_ADDR_CLEAR, 16'h0000);
        stat(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        check(flags(), 16'h0008);
        measure(16'h03e9, 16'h0000, 16'h0000);
        wr(`FLM_ADDR_CLEAR, 16'h0000);
        stat(8'h01, 8'h80, 8'h40, 8'h00, 8'h00);
        check(16'(n_warn), 16'h0003);
        $display("test high voltage done");
        do_reset();
        wr(`FLM_ADDR_VOUT_TARGET, 16'h0320);
        wr(`FLM_ADDR_UV_WARN, 16'h02bc);
        wr(`FLM_ADDR_UV_FAULT, 16'h0258);
        wr(`FLM_ADDR_UV_RESP, INH);
        measure(16'h0064, 16'h0000, 16'h0000);
        stat(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        wr(`FLM_ADDR_CTRL, 16'h0001);
        measure(16'h0064, 16'h0000, 16'h0000);
        stat(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        measure(16'h0320, 16'h0000, 16'h0000);
        measure(16'h028a, 16'h0000, 16'h0000);
        stat(8'h01, 8'h80, 8'h20, 8'h00, 8'h00);
        measure(16'h01f4, 16'h0000, 16'h0000);
        stat(8'h01, 8'h80, 8'h30, 8'h00, 8'h00);
        check(flags(), 16'h0004);
        check(16'(n_fault), 16'h0001);
        wr(`FLM_ADDR_CTRL, 16'h0000);
        measure(16'h01f4, 16'h0000, 16'h0000);
        check(flags(), 16'h0000);
        $display("test low voltage done");
        do_reset();
        wr(`FLM_ADDR_OC_WARN, 16'h0064);
        wr(`FLM_ADDR_OC_FAULT, 16'h00c8);
        wr(`FLM_ADDR_OC_LV, 16'h012c);
        wr(`FLM_ADDR_OC_RESP, {14'h0000, `FLM_RESP_LIMIT});
        wr(`FLM_ADDR_OC_LV_RESP, INH);
        wr(`FLM_ADDR_CTRL, 16'h0001);
        measure(16'h0320, 16'h0096, 16'h0000);
        stat(8'h01, 8'h40, 8'h00, 8'h20, 8'h00);
        measure(16'h0320, 16'h00fa, 16'h0000);
        stat(8'h11, 8'h40, 8'h00, 8'ha0, 8'h00);
        check(flags(), 16'h0001);
        measure(16'h00c8, 16'h00fa, 16'h0000);
        stat(8'h11, 8'h40, 8'h00, 8'he0, 8'h00);
        check(flags(), 16'h0004);
        wr(`FLM_ADDR_CTRL, 16'h0000);
        wr(`FLM_ADDR_OC_RESP, INH);
        measure(16'h0320, 16'h00fa, 16'h0000);
        check(flags(), 16'h0000);
        wr(`FLM_ADDR_CTRL, 16'h0001);
        measure(16'h0320, 16'h00fa, 16'h0000);
        check(flags(), 16'h0004);
        $display("test overcurrent done");
        do_reset();
        wr(`FLM_ADDR_UC_FAULT, 16'hffce);
        wr(`FLM_ADDR_UC_RESP, INH);
        wr(`FLM_ADDR_CTRL, 16'h0001);
        measure(16'h0000, 16'hffce, 16'h0000);
        stat(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        measure(16'h0000, 16'hffcd, 16'h0000);
        stat(8'h01, 8'h40, 8'h00, 8'h10, 8'h00);
        check(flags(), 16'h0002);
        $display("test undercurrent done");
        do_reset();
        wr(`FLM_ADDR_OT_WARN, 16'h003c);
        wr(`FLM_ADDR_OT_FAULT, 16'h005a);
        wr(`FLM_ADDR_OT_RESP, INH);
        wr(`FLM_ADDR_CTRL, 16'h0001);
        measure(16'h0000, 16'h0000, 16'hfffb);
        stat(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        measure(16'h0000, 16'h0000, 16'h003d);
        stat(8'h04, 8'h00, 8'h00, 8'h00, 8'h40);
        measure(16'h0000, 16'h0000, 16'h005b);
        stat(8'h04, 8'h00, 8'h00, 8'h00, 8'hc0);
        check(flags(), 16'h0004);
        check(16'(n_fault), 16'h0001);
        $display("test temperature done");
        end_of_test();
    end
endmodule : flm_fault_limit_monitor_test
